// ---- core/irqavs_host.sv ----
// Host controller that initialises an 8-level interrupt controller,
// writes operation commands and runs its acknowledge sequences.
// Assumes the device pins are synchronous to CORE_CLK; bus is shared.
//
// Functional notes
// - 8-bit acknowledge uses exactly three strobes.
// - 16-bit acknowledge uses two strobes, no opcode.
// - Host writes three or four init words.
// - Operation words only after init completes.
`timescale 1ns/1ps
`default_nettype none
module irqavs_host (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // Configuration
  input  wire logic        CFG_SPACING4,
  input  wire logic        CFG_CPU16,
  input  wire logic        CFG_SINGLE,
  input  wire logic        CFG_LEVEL_TRIG,
  input  wire logic        CFG_AUTO_EOS,
  input  wire logic [15:0] CFG_ADDR,
  input  wire logic [7:0]  CFG_CASCADE,
  // User requests
  input  wire logic        INIT_REQ,
  input  wire logic        OPW_REQ,
  input  wire logic        OPW_A0,
  input  wire logic [7:0]  OPW_DATA,
  input  wire logic        ACK_REQ,
  // User status and results
  output logic             BUSY,
  output logic             INIT_DONE,
  output logic             OPW_DONE,
  output logic             ACK_DONE,
  output logic [15:0]      ACK_ADDR,
  output logic [7:0]       ACK_VECTOR,
  output logic [2:0]       ACK_LEVEL,
  output logic             ACK_BAD,
  // Device pins
  output logic             CS_N,
  output logic             A0,
  output logic             WR_N,
  output logic             ACK_STROBE_N,
  output logic [7:0]       D_O,
  output logic             D_OE,
  input  wire logic [7:0]  D_I
);

  // ****************************************************************
  // State
  // ****************************************************************
  irqavs_pkg::irqavs_state_t st_q;
  logic [1:0]  idx_q;
  logic [1:0]  pulse_q;
  logic        in_init_q;
  logic        mode16_q;
  logic        spc4_q;
  logic        single_q;
  logic        ltim_q;
  logic        aeos_q;
  logic [15:0] addr_q;
  logic [7:0]  casc_q;
  logic [7:0]  b0_q;
  logic [7:0]  b1_q;
  logic [7:0]  b2_q;
  logic        start_q;
  logic        kind_ack_q;
  logic        sample;
  logic        done;

  // ****************************************************************
  // Init word build
  // ****************************************************************
  logic [7:0] iw_first;
  logic [7:0] iw_last;
  logic [7:0] word_mux;
  logic [1:0] idx_next;
  always_comb begin
    iw_first = {addr_q[7:5], 5'h00};
    iw_first[irqavs_pkg::IW1_MARK_BIT]   = 1'b1;
    iw_first[irqavs_pkg::IW1_LTIM_BIT]   = ltim_q;
    iw_first[irqavs_pkg::IW1_SPC4_BIT]   = spc4_q;
    iw_first[irqavs_pkg::IW1_SINGLE_BIT] = single_q;
    // Last word always sent, so family and auto mode are explicit
    iw_first[irqavs_pkg::IW1_IC4_BIT]    = 1'b1;
    iw_last = 8'h00;
    iw_last[irqavs_pkg::IW4_CPU16_BIT]   = mode16_q;
    iw_last[irqavs_pkg::IW4_AEOS_BIT]    = aeos_q;
  end

  // cascade word skipped in single configuration
  assign idx_next = (idx_q == irqavs_pkg::IW_SECOND && single_q) ?
                    irqavs_pkg::IW_LAST : idx_q + 2'h1;
  // Looks ahead: the word queued is the one about to be sent
  assign word_mux = (idx_next == irqavs_pkg::IW_FIRST)  ? iw_first :
                    (idx_next == irqavs_pkg::IW_SECOND) ? addr_q[15:8] :
                    (idx_next == irqavs_pkg::IW_CASC)   ? casc_q : iw_last;

  // ****************************************************************
  // Acknowledge decode
  // ****************************************************************
  wire [1:0] pulse_last = mode16_q ? irqavs_pkg::ACK_PULSES_16B
                                   : irqavs_pkg::ACK_PULSES_8B;
  wire [2:0] lvl_spc4 = b1_q[irqavs_pkg::SPC4_LVL_LSB +: 3];
  wire [2:0] lvl_spc8 = b1_q[irqavs_pkg::SPC8_LVL_LSB +: 3];
  // vector carries level in low bits; spacing unused
  wire [2:0] lvl_dec  = mode16_q ? b1_q[2:0]
                                 : (spc4_q ? lvl_spc4 : lvl_spc8);
  // first 8-bit byte must be the call opcode
  wire       bad_dec  = !mode16_q && (b0_q != irqavs_pkg::CALL_OPCODE);
  wire       req_idle = (st_q == irqavs_pkg::ST_IDLE);
  wire       last_p   = (pulse_q == pulse_last);

  // ****************************************************************
  // Strobe timing
  // ****************************************************************
  irqavs_strobe u_strobe (
    .clk      (CORE_CLK),
    .rst      (RST),
    .start    (start_q),
    .to_ack   (kind_ack_q),
    .wr_n_q   (WR_N),
    .ack_n_q  (ACK_STROBE_N),
    .sample_q (sample),
    .done_q   (done)
  );

  // ****************************************************************
  // Configuration latch
  // ****************************************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mode16_q <= 1'b0;
      spc4_q   <= 1'b0;
      single_q <= 1'b1;
      ltim_q   <= 1'b0;
      aeos_q   <= 1'b0;
      addr_q   <= 16'h0000;
      casc_q   <= 8'h00;
    end else if (req_idle && INIT_REQ) begin
      // Decode must follow what the device was told, not live inputs
      mode16_q <= CFG_CPU16;
      spc4_q   <= CFG_SPACING4;
      single_q <= CFG_SINGLE;
      ltim_q   <= CFG_LEVEL_TRIG;
      aeos_q   <= CFG_AUTO_EOS;
      addr_q   <= CFG_ADDR;
      casc_q   <= CFG_CASCADE;
    end
  end

  // ****************************************************************
  // Acknowledge byte capture
  // ****************************************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      b0_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
    end else if (sample && st_q == irqavs_pkg::ST_ACK) begin
      // first 16-bit slot floats, its byte is never used
      unique case (pulse_q)
        2'h0:    b0_q <= D_I;
        2'h1:    b1_q <= D_I;
        default: b2_q <= D_I;
      endcase
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_q       <= irqavs_pkg::ST_IDLE;
      idx_q      <= irqavs_pkg::IW_FIRST;
      pulse_q    <= 2'h0;
      in_init_q  <= 1'b0;
      start_q    <= 1'b0;
      kind_ack_q <= 1'b0;
      BUSY       <= 1'b0;
      INIT_DONE  <= 1'b0;
      OPW_DONE   <= 1'b0;
      ACK_DONE   <= 1'b0;
      ACK_ADDR   <= 16'h0000;
      ACK_VECTOR <= 8'h00;
      ACK_LEVEL  <= 3'h0;
      ACK_BAD    <= 1'b0;
      CS_N       <= 1'b1;
      A0         <= 1'b0;
      D_O        <= 8'h00;
      D_OE       <= 1'b0;
    end else begin
      start_q  <= 1'b0;
      OPW_DONE <= 1'b0;
      ACK_DONE <= 1'b0;
      unique case (st_q)
        irqavs_pkg::ST_IDLE: begin
          if (INIT_REQ) begin
            // first init word opens the sequence
            st_q       <= irqavs_pkg::ST_WORD;
            in_init_q  <= 1'b1;
            INIT_DONE  <= 1'b0;
            idx_q      <= irqavs_pkg::IW_FIRST;
            kind_ack_q <= 1'b0;
            start_q    <= 1'b1;
            BUSY       <= 1'b1;
            CS_N       <= 1'b0;
            A0         <= 1'b0;
            D_OE       <= 1'b1;
            // Latch not loaded yet, so build the first word directly
            D_O        <= {CFG_ADDR[7:5], 1'b1, CFG_LEVEL_TRIG,
                           CFG_SPACING4, CFG_SINGLE, 1'b1};
          end else if (OPW_REQ && INIT_DONE) begin
            // operation words only once init is complete
            st_q       <= irqavs_pkg::ST_WORD;
            kind_ack_q <= 1'b0;
            start_q    <= 1'b1;
            BUSY       <= 1'b1;
            CS_N       <= 1'b0;
            A0         <= OPW_A0;
            D_O        <= OPW_DATA;
            D_OE       <= 1'b1;
          end else if (ACK_REQ && INIT_DONE) begin
            // host never drives the bus while the device answers
            st_q       <= irqavs_pkg::ST_ACK;
            pulse_q    <= 2'h0;
            kind_ack_q <= 1'b1;
            start_q    <= 1'b1;
            BUSY       <= 1'b1;
            D_OE       <= 1'b0;
          end
        end
        irqavs_pkg::ST_WORD: begin
          if (done) begin
            if (in_init_q && idx_q != irqavs_pkg::IW_LAST) begin
              // Chip select held low across the whole init burst
              idx_q   <= idx_next;
              start_q <= 1'b1;
              A0      <= 1'b1;
              D_O     <= word_mux;
            end else begin
              st_q      <= irqavs_pkg::ST_IDLE;
              BUSY      <= 1'b0;
              CS_N      <= 1'b1;
              D_OE      <= 1'b0;
              in_init_q <= 1'b0;
              INIT_DONE <= INIT_DONE | in_init_q;
              OPW_DONE  <= !in_init_q;
            end
          end
        end
        irqavs_pkg::ST_ACK: begin
          if (done) begin
            if (!last_p) begin
              // further strobes until the sequence is complete
              pulse_q <= pulse_q + 2'h1;
              start_q <= 1'b1;
            end else begin
              st_q       <= irqavs_pkg::ST_IDLE;
              BUSY       <= 1'b0;
              ACK_DONE   <= 1'b1;
              // low address byte; high byte from third slot
              ACK_ADDR   <= {b2_q, b1_q};
              ACK_VECTOR <= b1_q;
              // a dropped request simply decodes as level 7
              ACK_LEVEL  <= lvl_dec;
              ACK_BAD    <= bad_dec;
            end
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- core/irqavs_pkg.sv ----
// Constants shared by the interrupt-acknowledge host controller.
// Assumes a 25 MHz core clock; pin timings are converted to cycles here.
package irqavs_pkg;

  // ****************************************************************
  // Clock and pin timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 40;
  localparam int STROBE_LOW_NS   = 200;
  localparam int STROBE_REC_NS   = 200;
  // Least times round up to whole cycles
  localparam int STROBE_LOW_CYC  =
    (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_REC_CYC  =
    (STROBE_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Acknowledge byte formats
  // ****************************************************************
  localparam logic [7:0] CALL_OPCODE    = 8'hcd;
  localparam logic [1:0] ACK_PULSES_8B  = 2'h2;  // last index, 3 pulses
  localparam logic [1:0] ACK_PULSES_16B = 2'h1;  // last index, 2 pulses
  localparam int SPC4_LVL_LSB = 2;
  localparam int SPC8_LVL_LSB = 3;

  // ****************************************************************
  // Init command word bit positions
  // ****************************************************************
  localparam int IW1_IC4_BIT    = 0;
  localparam int IW1_SINGLE_BIT = 1;
  localparam int IW1_SPC4_BIT   = 2;
  localparam int IW1_LTIM_BIT   = 3;
  localparam int IW1_MARK_BIT   = 4;
  localparam int IW4_CPU16_BIT  = 0;
  localparam int IW4_AEOS_BIT   = 1;

  // Init word slots
  localparam logic [1:0] IW_FIRST  = 2'h0;
  localparam logic [1:0] IW_SECOND = 2'h1;
  localparam logic [1:0] IW_CASC   = 2'h2;
  localparam logic [1:0] IW_LAST   = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_WORD, ST_ACK} irqavs_state_t;

endpackage

// ---- core/irqavs_strobe.sv ----
// Active-low strobe generator for the write and acknowledge pins.
// Assumes start only arrives while idle; one pulse per start.
`timescale 1ns/1ps
`default_nettype none
module irqavs_strobe #(
  parameter int LOW_CYC = irqavs_pkg::STROBE_LOW_CYC,
  parameter int REC_CYC = irqavs_pkg::STROBE_REC_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  input  wire logic to_ack,
  // Pins
  output var  logic wr_n_q,
  output var  logic ack_n_q,
  // Events
  output var  logic sample_q,
  output var  logic done_q
);

  generate
    if (LOW_CYC < 1 || REC_CYC < 1 || LOW_CYC > 255 || REC_CYC > 255) begin
      $error("irqavs_strobe: strobe counts must be 1..255");
    end
  endgenerate

  localparam logic [7:0] LOW_LAST = 8'(LOW_CYC - 1);
  localparam logic [7:0] REC_LAST = 8'(REC_CYC - 1);

  logic [7:0] cnt_q;
  logic       low_q;
  logic       rec_q;

  wire low_end = low_q && (cnt_q == LOW_LAST);
  wire rec_end = rec_q && (cnt_q == REC_LAST);
  wire start_ok = start && !low_q && !rec_q;
  // Sample flag stands in the last low cycle, while the device still drives
  wire low_next = start_ok ? (LOW_LAST == 8'h00)
                           : (low_q && !low_end &&
                              (cnt_q + 8'h01 == LOW_LAST));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q    <= 8'h00;
      low_q    <= 1'b0;
      rec_q    <= 1'b0;
      wr_n_q   <= 1'b1;
      ack_n_q  <= 1'b1;
      sample_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      sample_q <= low_next;
      done_q   <= rec_end;
      if (start_ok) begin
        low_q   <= 1'b1;
        cnt_q   <= 8'h00;
        wr_n_q  <= to_ack;
        ack_n_q <= !to_ack;
      end else if (low_end) begin
        // Data is sampled on the rising edge, just before release
        low_q   <= 1'b0;
        rec_q   <= 1'b1;
        cnt_q   <= 8'h00;
        wr_n_q  <= 1'b1;
        ack_n_q <= 1'b1;
      end else if (rec_end) begin
        rec_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/irqavs_dev_model.sv ----
// Behavioural 8-level interrupt controller acting on strobe edges.
// Assumes the host holds data stable across each write strobe.
`timescale 1ns/1ps
`default_nettype none
module irqavs_dev_model (
  // Host pins
  input  wire logic       cs_n, a0, wr_n, ack_n,
  input  wire logic [7:0] d_o,
  // Bench controls
  input  wire logic [2:0] level,
  input  wire logic       bad_call,
  // Data towards host
  output logic      [7:0] d_i
);
  logic [7:0] iw1_q, hi_q, casc_q, opw_q, drv_q, last_q;
  logic [2:0] lvl_q;
  logic [1:0] slot_q, idx_q;
  logic       cpu16_q, aeos_q, init_ok_q, in_svc_q, drv_on_q, low_seen_q;
  initial begin
    {iw1_q, hi_q, casc_q, opw_q, drv_q, last_q} = '0;
    {lvl_q, slot_q, idx_q, cpu16_q, aeos_q, init_ok_q, in_svc_q} = '0;
    {drv_on_q, low_seen_q} = 2'h0;
  end
  // released bus shows inverted last byte
  assign d_i = drv_on_q ? drv_q : ~last_q;
  always @(posedge wr_n) begin
    if (!cs_n) begin
      if (!a0 && d_o[4]) begin
        iw1_q = d_o;
        slot_q = 2'h1;
        init_ok_q = 1'b0;
      end else if (slot_q == 2'h1) begin
        hi_q = d_o;
        slot_q = iw1_q[1] ? 2'h3 : 2'h2;
      end else if (slot_q == 2'h2) begin
        casc_q = d_o;
        slot_q = 2'h3;
      end else if (slot_q == 2'h3) begin
        {aeos_q, cpu16_q} = d_o[1:0];
        slot_q = 2'h0;
        init_ok_q = 1'b1;
      end else if (init_ok_q) begin
        opw_q = d_o;
      end
    end
  end
  // winning level frozen on first pulse
  always @(negedge ack_n) begin
    low_seen_q = 1'b1;
    if (idx_q == 2'h0) begin
      lvl_q = level;
      in_svc_q = 1'b1;
    end
    if (cpu16_q) drv_q = {hi_q[7:3], lvl_q};
    else if (idx_q == 2'h0) drv_q = bad_call ? 8'h0c : 8'hcd;
    else if (idx_q == 2'h2) drv_q = hi_q;
    else if (iw1_q[2]) drv_q = {iw1_q[7:5], lvl_q, 2'h0};
    else drv_q = {iw1_q[7:6], lvl_q, 3'h0};
    // no byte in first 16-bit cycle
    drv_on_q = !(cpu16_q && idx_q == 2'h0);
  end
  // pulse count and auto end of service
  // Power-up rise of the pin is no pulse and must not advance the count
  always @(posedge ack_n) begin
    #10;
    if (low_seen_q) begin
      low_seen_q = 1'b0;
      last_q = drv_q;
      drv_on_q = 1'b0;
      if (idx_q == (cpu16_q ? 2'h1 : 2'h2)) begin
        idx_q = 2'h0;
        if (aeos_q) in_svc_q = 1'b0;
      end else idx_q = idx_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/irqavs_monitor.sv ----
// Port checker for the acknowledge host: strobe counts and bus use.
// Bound to irqavs_host; assumes its default five-cycle strobe low time.
`timescale 1ns/1ps
`default_nettype none
module irqavs_monitor (
  // Clock, reset and configuration
  input wire logic       CORE_CLK, RST, CFG_CPU16, CFG_SINGLE,
  // User side
  input wire logic       INIT_REQ, OPW_REQ, ACK_REQ, BUSY,
  input wire logic       INIT_DONE, OPW_DONE, ACK_DONE,
  // Device pins
  input wire logic       CS_N, A0, WR_N, ACK_STROBE_N, D_OE,
  input wire logic [7:0] D_O
);
  // ****************************************************************
  // Strobe counters
  // ****************************************************************
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic       cpu16_q, single_q, ack_prev_q, wr_prev_q, take;
  logic [2:0] ack_cnt_q, wr_cnt_q;
  // Cleared on the taking edge, so a DONE cycle still sees the count
  assign take = !BUSY && (INIT_REQ || OPW_REQ || ACK_REQ);
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      {cpu16_q, single_q, ack_cnt_q, wr_cnt_q} <= '0;
      {ack_prev_q, wr_prev_q} <= 2'h3;
    end else begin
      ack_prev_q <= ACK_STROBE_N;
      wr_prev_q  <= WR_N;
      if (INIT_REQ && !BUSY) begin
        cpu16_q  <= CFG_CPU16;
        single_q <= CFG_SINGLE;
      end
      ack_cnt_q <= take ? 3'h0 : ack_cnt_q + {2'h0, ack_prev_q & ~ACK_STROBE_N};
      wr_cnt_q  <= take ? 3'h0 : wr_cnt_q + {2'h0, wr_prev_q & ~WR_N};
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_ack_cnt8;
    ACK_DONE && !cpu16_q |-> ack_cnt_q == 3'h3;
  endproperty
  a_ack_cnt8: assert property (p_ack_cnt8) else $error("ack count 8b");
  property p_ack_cnt16;
    ACK_DONE && cpu16_q |-> ack_cnt_q == 3'h2;
  endproperty
  a_ack_cnt16: assert property (p_ack_cnt16) else $error("ack count");
  property p_init_cnt;
    $rose(INIT_DONE) |-> wr_cnt_q == (single_q ? 3'h3 : 3'h4);
  endproperty
  a_init_cnt: assert property (p_init_cnt) else $error("init words");
  property p_opw_one;
    OPW_DONE |-> wr_cnt_q == 3'h1 && INIT_DONE;
  endproperty
  a_opw_one: assert property (p_opw_one) else $error("op write");
  property p_refuse;
    !BUSY && !INIT_DONE && !INIT_REQ && (OPW_REQ || ACK_REQ) |=> !BUSY;
  endproperty
  a_refuse: assert property (p_refuse) else $error("early request");
  property p_ack_float;
    !ACK_STROBE_N |-> !D_OE && WR_N;
  endproperty
  a_ack_float: assert property (p_ack_float) else $error("bus fight");
  property p_wr_hold;
    !WR_N && !$past(WR_N) |-> $stable(D_O) && $stable(A0) && !CS_N && D_OE;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write moved");
  property p_strobe_low;
    $fell(ACK_STROBE_N) |-> !ACK_STROBE_N [*5] ##1 ACK_STROBE_N;
  endproperty
  a_strobe_low: assert property (p_strobe_low) else $error("ack width");
endmodule
bind irqavs_host irqavs_monitor u_mon (.CORE_CLK(CORE_CLK), .RST(RST),
  .CFG_CPU16(CFG_CPU16), .CFG_SINGLE(CFG_SINGLE), .INIT_REQ(INIT_REQ),
  .OPW_REQ(OPW_REQ), .ACK_REQ(ACK_REQ), .BUSY(BUSY), .INIT_DONE(INIT_DONE),
  .OPW_DONE(OPW_DONE), .ACK_DONE(ACK_DONE), .CS_N(CS_N), .A0(A0),
  .WR_N(WR_N), .ACK_STROBE_N(ACK_STROBE_N), .D_OE(D_OE), .D_O(D_O));
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the acknowledge host controller.
// A behavioural device answers on the pins; checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst, s4, c16, sgl, ltim, aeos, init_req, opw_req;
  logic        opw_a0, ack_req, bad_call, busy, init_done, opw_done;
  logic        ack_done, ack_bad, cs_n, a0, wr_n, ack_n, d_oe;
  logic [15:0] addr, ack_addr;
  logic [7:0]  casc, opw_data, ack_vector, d_o, d_i;
  logic [2:0]  lvl, ack_level;
  int          err_count, n_tests, l;
  irqavs_host uut (.CORE_CLK(clk), .RST(rst), .CFG_SPACING4(s4),
    .CFG_CPU16(c16), .CFG_SINGLE(sgl), .CFG_LEVEL_TRIG(ltim),
    .CFG_AUTO_EOS(aeos), .CFG_ADDR(addr), .CFG_CASCADE(casc),
    .INIT_REQ(init_req), .OPW_REQ(opw_req), .OPW_A0(opw_a0),
    .OPW_DATA(opw_data), .ACK_REQ(ack_req), .BUSY(busy),
    .INIT_DONE(init_done), .OPW_DONE(opw_done), .ACK_DONE(ack_done),
    .ACK_ADDR(ack_addr), .ACK_VECTOR(ack_vector), .ACK_LEVEL(ack_level),
    .ACK_BAD(ack_bad), .CS_N(cs_n), .A0(a0), .WR_N(wr_n),
    .ACK_STROBE_N(ack_n), .D_O(d_o), .D_OE(d_oe), .D_I(d_i));
  irqavs_dev_model dev (.cs_n(cs_n), .a0(a0), .wr_n(wr_n), .ack_n(ack_n),
    .d_o(d_o), .level(lvl), .bad_call(bad_call), .d_i(d_i));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request for one taking edge, then bounded wait for completion
  task automatic run(input int k);
    int i;
    @(posedge clk);
    init_req <= (k == 0);
    opw_req  <= (k == 1);
    ack_req  <= (k == 2);
    @(posedge clk);
    {init_req, opw_req, ack_req} <= 3'h0;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if (k == 0 ? init_done === 1'b1 && busy === 1'b0 :
          k == 1 ? opw_done === 1'b1 : ack_done === 1'b1) break;
    end
    if (i == 400) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
  endtask
  task automatic setup(input logic a, b, c, d, e, input logic [15:0] ad);
    @(posedge clk);
    {s4, c16, sgl, ltim, aeos} <= {a, b, c, d, e};
    addr <= ad;
    run(0);
    chk(dev.iw1_q, {8'h00, ad[7:5], 1'b1, d, a, c, 1'b1});
    chk(dev.hi_q, ad[15:8]);
    chk(dev.cpu16_q, b);
    chk(dev.init_ok_q, 1'b1);
  endtask
  task automatic ack(input logic [2:0] v, input logic [15:0] exp);
    @(posedge clk);
    lvl <= v;
    run(2);
    chk(c16 ? {8'h00, ack_vector} : ack_addr, exp);
    chk(ack_level, v);
    chk(ack_bad, bad_call);
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst = 1'b1;
    {s4, c16, sgl, ltim, aeos, init_req, opw_req, opw_a0} = 8'h00;
    {ack_req, bad_call, lvl, addr, opw_data} = '0;
    casc = 8'h04;
    err_count = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    {opw_req, ack_req} <= 2'h3;
    @(posedge clk);
    {opw_req, ack_req} <= 2'h0;
    repeat (4) @(posedge clk);
    #1 chk(busy, 1'b0);
    setup(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 16'h5aa0);
    for (l = 0; l < 8; l++) begin
      ack(l[2:0], {8'h5a, 3'h5, l[2:0], 2'h0});
      chk(dev.in_svc_q, 1'b0);
    end
    @(posedge clk);
    opw_a0 <= 1'b1;
    opw_data <= 8'ha5;
    run(1);
    chk(dev.opw_q, 8'ha5);
    setup(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 16'h3cc0);
    chk(dev.casc_q, casc);
    for (l = 0; l < 8; l++) begin
      ack(l[2:0], {8'h3c, 2'h3, l[2:0], 3'h0});
      chk(dev.in_svc_q, 1'b1);
    end
    setup(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 16'habe0);
    for (l = 0; l < 8; l++) begin
      ack(l[2:0], {8'h00, 5'h15, l[2:0]});
    end
    setup(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h5aa0);
    @(posedge clk);
    bad_call <= 1'b1;
    ack(3'h2, {8'h5a, 3'h5, 3'h2, 2'h0});
    wrap_up;
  end
  // Whole run needs roughly 1100 cycles; 20000 is a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
